// *** hdl/drx_serial_ctrl.sv ***
`include "drx_params.svh"

// Function
// - shift data on serial rising edge, strobe low
// - keep only the latest 32 bits
// - strobe rising copies word to register
// - low four bits pick the register
// - readback output returns register content
// - latch-hold pin gates each channel gain
// - separate 6-bit gain port per channel
// - per-channel enable pin powers channel
// - register 13 holds balun tuning fields
// - register 13 bits 26:25 lo bias
// - register 13 bits 24:22 rf bias
// - select bits decode unsigned 0 to 15
// - register 7 bit 22 picks gain source
// - gain applies only with latch-hold high
// - code 0 max gain, 63 min gain
module drx_serial_ctrl (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // serial port
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic LOAD_STROBE_I,
    output logic READBACK_OUT_O,
    // channel pins
    input wire logic [5:0] CHAN_A_GAIN_PINS_I,
    input wire logic [5:0] CHAN_B_GAIN_PINS_I,
    input wire logic CHAN_A_LATCH_I,
    input wire logic CHAN_B_LATCH_I,
    input wire logic CHAN_A_POWER_ON_I,
    input wire logic CHAN_B_POWER_ON_I,
    // control outputs to the analog side
    output logic [5:0] CHAN_A_ATTEN_O,
    output logic [5:0] CHAN_B_ATTEN_O,
    output logic CHAN_A_ACTIVE_O,
    output logic CHAN_B_ACTIVE_O,
    output logic [1:0] LO_BIAS_CODE_O,
    output logic [2:0] RF_VI_BIAS_CODE_O,
    output logic [2:0] BALUN_IN_TUNE_O,
    output logic [2:0] BALUN_OUT_TUNE_O
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pin_async;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    assign pin_async = {SER_CLK_I, SER_DATA_I, LOAD_STROBE_I, CHAN_A_LATCH_I,
                        CHAN_B_LATCH_I, CHAN_A_POWER_ON_I, CHAN_B_POWER_ON_I,
                        2'b00};

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            // idle levels, so a strobe held high at release cannot look like a load edge
            sync1_ff <= `DRX_PIN_IDLE;
            sync2_ff <= `DRX_PIN_IDLE;
        end else begin
            sync1_ff <= pin_async;
            sync2_ff <= sync1_ff;
        end
    end

    logic sclk_s;
    logic sdata_s;
    logic strobe_s;
    logic latch_a_s;
    logic latch_b_s;
    logic pwr_a_s;
    logic pwr_b_s;
    assign sclk_s = sync2_ff[8];
    assign sdata_s = sync2_ff[7];
    assign strobe_s = sync2_ff[6];
    assign latch_a_s = sync2_ff[5];
    assign latch_b_s = sync2_ff[4];
    assign pwr_a_s = sync2_ff[3];
    assign pwr_b_s = sync2_ff[2];

    // gain pins are buses; the latch gate samples their two-flop copy when the latch is high and the parallel source is picked
    logic [11:0] gain_s1_ff;
    logic [11:0] gain_s2_ff;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            gain_s1_ff <= '0;
            gain_s2_ff <= '0;
        end else begin
            gain_s1_ff <= {CHAN_A_GAIN_PINS_I, CHAN_B_GAIN_PINS_I};
            gain_s2_ff <= gain_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic sclk_d_ff;
    logic strobe_d_ff;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sclk_d_ff <= 1'b0;
            strobe_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            strobe_d_ff <= strobe_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic load_evt;
    logic shift_en;
    assign sclk_rise = sclk_s & ~sclk_d_ff;
    assign sclk_fall = ~sclk_s & sclk_d_ff;
    assign load_evt = strobe_s & ~strobe_d_ff;
    assign shift_en = sclk_rise & ~strobe_s;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    logic [`DRX_WORD_W-1:0] shift_ff;
    logic [`DRX_WORD_W-1:0] nxt_shift;
    // msb first; older bits fall off the top, leaving the last 32
    assign nxt_shift = shift_en ? {shift_ff[`DRX_WORD_W-2:0], sdata_s} : shift_ff;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            shift_ff <= '0;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [`DRX_WORD_W-1:0] regs_ff [`DRX_NUM_REGS];
    logic [3:0] sel_idx;
    assign sel_idx = shift_ff[`DRX_SEL_MSB:`DRX_SEL_LSB];

    genvar gi;
    generate
        for (gi = 0; gi < `DRX_NUM_REGS; gi++) begin : g_reg
            logic hit;
            assign hit = load_evt && (sel_idx == 4'(gi));
            always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
                if (!RST_N_I) begin
                    regs_ff[gi] <= `DRX_REG_RESET;
                end else if (hit) begin
                    regs_ff[gi] <= shift_ff;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    // the word last loaded is reloaded for readback on the strobe edge
    // and shifted out msb first on serial falling edges
    logic [`DRX_WORD_W-1:0] rb_ff;
    logic [`DRX_WORD_W-1:0] nxt_rb;
    assign nxt_rb = load_evt ? shift_ff :
                    (sclk_fall & ~strobe_s) ? {rb_ff[`DRX_WORD_W-2:0], 1'b0} : rb_ff;

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rb_ff <= '0;
            READBACK_OUT_O <= 1'b0;
        end else begin
            rb_ff <= nxt_rb;
            READBACK_OUT_O <= nxt_rb[`DRX_WORD_W-1];
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [`DRX_WORD_W-1:0] mix_reg;
    logic [`DRX_WORD_W-1:0] gain_reg;
    drx_pkg::drx_gain_src_t gain_src;
    drx_pkg::drx_gain_t src_a;
    drx_pkg::drx_gain_t src_b;
    assign mix_reg = regs_ff[`DRX_IDX_MIX_BIAS];
    assign gain_reg = regs_ff[`DRX_IDX_GAIN];
    assign gain_src = drx_pkg::drx_gain_src_t'(
        regs_ff[`DRX_IDX_GAIN_SRC][`DRX_GAIN_SRC_BIT]);
    assign src_a = (gain_src == drx_pkg::DRX_GAIN_PARALLEL) ? gain_s2_ff[11:6] :
                   gain_reg[`DRX_GAIN_A_MSB:`DRX_GAIN_A_LSB];
    assign src_b = (gain_src == drx_pkg::DRX_GAIN_PARALLEL) ? gain_s2_ff[5:0] :
                   gain_reg[`DRX_GAIN_B_MSB:`DRX_GAIN_B_LSB];

    // ------------------------------------------------------------
    // output latches
    // ------------------------------------------------------------
    // attenuation code passes straight: 0 is max gain, 63 is min gain
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CHAN_A_ATTEN_O <= '0;
            CHAN_B_ATTEN_O <= '0;
            CHAN_A_ACTIVE_O <= 1'b0;
            CHAN_B_ACTIVE_O <= 1'b0;
            LO_BIAS_CODE_O <= '0;
            RF_VI_BIAS_CODE_O <= '0;
            BALUN_IN_TUNE_O <= '0;
            BALUN_OUT_TUNE_O <= '0;
        end else begin
            if (latch_a_s) begin
                CHAN_A_ATTEN_O <= src_a;
            end
            if (latch_b_s) begin
                CHAN_B_ATTEN_O <= src_b;
            end
            CHAN_A_ACTIVE_O <= pwr_a_s;
            CHAN_B_ACTIVE_O <= pwr_b_s;
            LO_BIAS_CODE_O <= mix_reg[`DRX_LO_BIAS_MSB:`DRX_LO_BIAS_LSB];
            RF_VI_BIAS_CODE_O <= mix_reg[`DRX_VI_BIAS_MSB:`DRX_VI_BIAS_LSB];
            BALUN_IN_TUNE_O <= mix_reg[`DRX_BAL_IN_MSB:`DRX_BAL_IN_LSB];
            BALUN_OUT_TUNE_O <= mix_reg[`DRX_BAL_OUT_MSB:`DRX_BAL_OUT_LSB];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_SHIFT_IN: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        shift_en |=> shift_ff == {$past(shift_ff[`DRX_WORD_W-2:0]), $past(sdata_s)})
        else $error("shift did not take serial bit");
    AST_DROP_OLD: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        shift_en |=> shift_ff[`DRX_WORD_W-1] == $past(shift_ff[`DRX_WORD_W-2]))
        else $error("shift register did not drop oldest bit");
    AST_LOAD_COPY: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        load_evt |=> regs_ff[$past(sel_idx)] == $past(shift_ff))
        else $error("load did not copy word to addressed register");
    AST_STROBE_HIGH_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (strobe_s && $past(strobe_s)) |=> $stable(shift_ff))
        else $error("shift register moved while strobe high");
    AST_ONLY_ADDRESSED: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        load_evt && sel_idx != `DRX_IDX_MIX_BIAS |=> $stable(mix_reg))
        else $error("unaddressed register changed on load");
    AST_READBACK: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        load_evt |=> READBACK_OUT_O == $past(shift_ff[`DRX_WORD_W-1]))
        else $error("readback does not show loaded word msb");
    AST_LATCH_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !latch_a_s |=> $stable(CHAN_A_ATTEN_O))
        else $error("channel a gain changed with latch low");
    AST_GAIN_SRC: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (latch_b_s && gain_src == drx_pkg::DRX_GAIN_SERIAL) |=>
        CHAN_B_ATTEN_O == $past(gain_reg[`DRX_GAIN_B_MSB:`DRX_GAIN_B_LSB]))
        else $error("serial gain not applied to channel b");
    AST_POWER_PIN: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(pwr_a_s) |=> CHAN_A_ACTIVE_O)
        else $error("channel a enable not followed");
    AST_BIAS_FIELDS: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ##1 (LO_BIAS_CODE_O == $past(mix_reg[26:25])
        && RF_VI_BIAS_CODE_O == $past(mix_reg[24:22])
        && BALUN_IN_TUNE_O == $past(mix_reg[12:10])))
        else $error("bias or balun field misrouted");
    AST_BALUN_OUT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ##1 (BALUN_OUT_TUNE_O == $past(mix_reg[`DRX_BAL_OUT_MSB:`DRX_BAL_OUT_LSB])))
        else $error("balun output field misrouted");
    AST_READBACK_SHIFT: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (sclk_fall && !strobe_s) |=> READBACK_OUT_O == $past(rb_ff[`DRX_WORD_W-2]))
        else $error("readback did not advance on serial falling edge");
    AST_STROBE_HIGH_REGS: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (strobe_s && $past(strobe_s)) |=> ($stable(mix_reg) && $stable(gain_reg)))
        else $error("control register moved while strobe high");
    AST_ONLY_ADDRESSED_GAIN: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (load_evt && sel_idx != `DRX_IDX_GAIN) |=> $stable(gain_reg))
        else $error("gain register changed on load to another index");

    // channel b hold and power, channel a serial gain and the parallel path mirror the single-channel checks above;
    // parallel gain is held against the synced pins, not the raw port
    AST_LATCH_HOLD_B: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !latch_b_s |=> $stable(CHAN_B_ATTEN_O))
        else $error("channel b gain changed with latch low");
    AST_GAIN_SRC_A: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (latch_a_s && gain_src == drx_pkg::DRX_GAIN_SERIAL) |=>
        CHAN_A_ATTEN_O == $past(gain_reg[`DRX_GAIN_A_MSB:`DRX_GAIN_A_LSB]))
        else $error("serial gain not applied to channel a");
    AST_PAR_GAIN_A: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (latch_a_s && gain_src == drx_pkg::DRX_GAIN_PARALLEL) |=>
        CHAN_A_ATTEN_O == $past(gain_s2_ff[11:6]))
        else $error("parallel gain not applied to channel a");
    AST_PAR_GAIN_B: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (latch_b_s && gain_src == drx_pkg::DRX_GAIN_PARALLEL) |=>
        CHAN_B_ATTEN_O == $past(gain_s2_ff[5:0]))
        else $error("parallel gain not applied to channel b");
    AST_POWER_PIN_B: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(pwr_b_s) |=> CHAN_B_ACTIVE_O)
        else $error("channel b enable not followed");
    AST_POWER_OFF_A: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $fell(pwr_a_s) |=> !CHAN_A_ACTIVE_O)
        else $error("channel a did not power down");
    AST_POWER_OFF_B: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $fell(pwr_b_s) |=> !CHAN_B_ACTIVE_O)
        else $error("channel b did not power down");

endmodule

// *** hdl/drx_params.svh ***
`ifndef DRX_PARAMS_SVH
`define DRX_PARAMS_SVH

// ------------------------------------------------------------
// word layout
// ------------------------------------------------------------
`define DRX_WORD_W 32
`define DRX_SEL_MSB 3
`define DRX_SEL_LSB 0
`define DRX_NUM_REGS 16
`define DRX_REG_RESET 32'h0000_0000
// synchroniser reset: strobe stage high, every other pin low
`define DRX_PIN_IDLE 9'h040

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define DRX_IDX_GAIN_SRC 4'h7
`define DRX_IDX_MIX_BIAS 4'hd
`define DRX_IDX_GAIN 4'he

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DRX_GAIN_SRC_BIT 22
`define DRX_LO_BIAS_MSB 26
`define DRX_LO_BIAS_LSB 25
`define DRX_VI_BIAS_MSB 24
`define DRX_VI_BIAS_LSB 22
`define DRX_BAL_IN_MSB 12
`define DRX_BAL_IN_LSB 10
`define DRX_BAL_OUT_MSB 9
`define DRX_BAL_OUT_LSB 7
`define DRX_GAIN_A_MSB 17
`define DRX_GAIN_A_LSB 12
`define DRX_GAIN_B_MSB 11
`define DRX_GAIN_B_LSB 6
`define DRX_GAIN_W 6

`endif

// *** hdl/drx_pkg.sv ***
package drx_pkg;
    // gain source picked by the select bit
    typedef enum logic {
        DRX_GAIN_SERIAL,
        DRX_GAIN_PARALLEL
    } drx_gain_src_t;
    typedef logic [5:0] drx_gain_t;
endpackage

// *** sim/drx_host_model.sv ***
module drx_host_model (
    // clock
    input wire logic clk_i,
    // serial lines toward the device
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_strobe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        load_strobe_o = 1'b1;
    end

    // half of the 800 ns serial period
    task automatic half_bit();
        repeat (4) @(posedge clk_i);
    endtask

    // --------------------------------------------------------
    // one frame, serial clock idle low outside it
    // --------------------------------------------------------
    task automatic send(input logic [35:0] bits, input int n);
        @(posedge clk_i);
        load_strobe_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            ser_data_o <= bits[i];
            half_bit();
            ser_clk_o <= 1'b1;
            half_bit();
            ser_clk_o <= 1'b0;
        end
        half_bit();
        load_strobe_o <= 1'b1;
        // stale data is flipped so a late sample cannot hit the last bit
        ser_data_o <= ~ser_data_o;
        repeat (12) @(posedge clk_i);
    endtask

    // clock edges with the strobe high
    task automatic ghost(input int n);
        repeat (n) begin
            @(posedge clk_i);
            ser_data_o <= ~ser_data_o;
            half_bit();
            ser_clk_o <= 1'b1;
            half_bit();
            ser_clk_o <= 1'b0;
        end
    endtask
endmodule

// *** sim/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int id; logic [31:0] exp; string name;} drx_note_t;
    logic core_clk, rst_n, ser_clk, ser_data, load_strobe, readback;
    logic latch_a, latch_b, pwr_a, pwr_b, act_a, act_b;
    logic [5:0] pins_a, pins_b, atten_a, atten_b;
    logic [1:0] lo_bias;
    logic [2:0] vi_bias, bal_in, bal_out;
    logic [31:0] r13, r14, last, w;
    int fails, check_count;
    drx_note_t notes[$];
    event chk_ev;

    drx_serial_ctrl drx_serial_ctrl_i (.CORE_CLK_I(core_clk), .RST_N_I(rst_n),
        .SER_CLK_I(ser_clk), .SER_DATA_I(ser_data), .LOAD_STROBE_I(load_strobe),
        .READBACK_OUT_O(readback), .CHAN_A_GAIN_PINS_I(pins_a), .CHAN_B_GAIN_PINS_I(pins_b),
        .CHAN_A_LATCH_I(latch_a), .CHAN_B_LATCH_I(latch_b), .CHAN_A_POWER_ON_I(pwr_a),
        .CHAN_B_POWER_ON_I(pwr_b), .CHAN_A_ATTEN_O(atten_a), .CHAN_B_ATTEN_O(atten_b),
        .CHAN_A_ACTIVE_O(act_a), .CHAN_B_ACTIVE_O(act_b), .LO_BIAS_CODE_O(lo_bias),
        .RF_VI_BIAS_CODE_O(vi_bias), .BALUN_IN_TUNE_O(bal_in), .BALUN_OUT_TUNE_O(bal_out));
    drx_host_model drx_host_model_i (.clk_i(core_clk), .ser_clk_o(ser_clk),
        .ser_data_o(ser_data), .load_strobe_o(load_strobe));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // --------------------------------------------------------
    // expectation queue and its watcher
    // --------------------------------------------------------
    function automatic logic [31:0] seen(input int id);
        case (id)
            0: return 32'(lo_bias);
            1: return 32'(vi_bias);
            2: return 32'(bal_in);
            3: return 32'(bal_out);
            4: return 32'(readback);
            5: return 32'(atten_a);
            6: return 32'(atten_b);
            7: return 32'(act_a);
            default: return 32'(act_b);
        endcase
    endfunction

    task automatic note(input int id, input logic [31:0] e, input string nm);
        notes.push_back('{id, e, nm});
    endtask

    // sampled at the falling edge, well clear of any output update
    task automatic settle();
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        -> chk_ev;
        // let the watcher drain the queue, and put the next stimulus on a rising edge
        @(posedge core_clk);
    endtask

    initial begin
        drx_note_t n;
        forever begin
            @(chk_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check_count++;
                if (seen(n.id) !== n.exp) begin
                    fails++;
                    $display("BAD %s expected %h seen %h", n.name, n.exp, seen(n.id));
                end
            end
        end
    end

    task automatic chk13();
        note(0, 32'(r13[26:25]), "lo_bias");
        note(1, 32'(r13[24:22]), "vi_bias");
        note(2, 32'(r13[12:10]), "balun_in");
        note(3, 32'(r13[9:7]), "balun_out");
        note(4, 32'(last[31]), "readback");
        settle();
    endtask

    task automatic gchk(input logic [5:0] a, input logic [5:0] b);
        note(5, 32'(a), "atten_a");
        note(6, 32'(b), "atten_b");
        settle();
    endtask

    task automatic test_done();
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        test_done();
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        void'($urandom(32'h6fb2));
        {rst_n, latch_a, latch_b, pwr_a, pwr_b} = '0;
        pins_a = '0;
        pins_b = '0;
        {r13, r14, last} = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk13();
        for (int k = 0; k < 16; k++) begin
            w = $urandom;
            w[3:0] = 4'(k);
            if (k == 7) w[22] = 1'b0;
            if (k == 13) w[24:22] = ($urandom % 2) ? 3'h3 : 3'h4;
            drx_host_model_i.send({4'($urandom), w}, (k == 13) ? 36 : 32);
            if (k == 13) r13 = w;
            if (k == 14) r14 = w;
            last = w;
            chk13();
        end
        drx_host_model_i.ghost(5);
        chk13();
        gchk(6'h0, 6'h0);
        latch_a <= 1'b1;
        latch_b <= 1'b1;
        gchk(r14[17:12], r14[11:6]);
        latch_a <= 1'b0;
        latch_b <= 1'b0;
        drx_host_model_i.send({4'h0, 32'h0040_0007}, 32);
        pins_a <= 6'($urandom);
        pins_b <= 6'($urandom);
        gchk(r14[17:12], r14[11:6]);
        latch_a <= 1'b1;
        latch_b <= 1'b1;
        gchk(pins_a, pins_b);
        latch_a <= 1'b0;
        pins_a <= ~pins_a;
        pins_b <= ~pins_b;
        gchk(pins_a, ~pins_b);
        for (int k = 1; k < 3; k++) begin
            pwr_a <= k[0];
            pwr_b <= k[1];
            note(7, 32'(k[0]), "act_a");
            note(8, 32'(k[1]), "act_b");
            settle();
        end
        test_done();
    end
endmodule
